//--- verilog/pm_port_ef.sv
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ns
module pm_port_ef (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Fuse and test port
  input  wire logic        clock_output_fuse,
  input  wire logic        test_port_enable,
  input  wire logic        tap_shift_state,
  input  wire logic        test_data_out,
  // Clock system
  input  wire logic        divided_clock_output,
  // Serial port
  input  wire logic        serial_sync_mode,
  input  wire logic        serial_clock_out,
  input  wire logic        receiver_enable,
  input  wire logic        transmitter_enable,
  input  wire logic        serial_transmit_data_pin,
  // Universal serial interface
  input  wire logic        two_wire_mode_active,
  input  wire logic        three_wire_mode_active,
  input  wire logic        usi_data_out,
  input  wire logic        usi_data_bit,
  input  wire logic        two_wire_clock_hold,
  input  wire logic        usi_start_irq_enable,
  // Analog comparator digital input disables
  input  wire logic        comp_pos_input_disable,
  input  wire logic        comp_neg_input_disable,
  // Port E pads
  input  wire logic [7:0]  port_e_in,
  output logic      [7:0]  port_e_out,
  output logic      [7:0]  port_e_oe_n,
  output logic      [7:0]  port_e_pullup,
  // Port F pads
  input  wire logic [7:0]  port_f_in,
  output logic      [7:0]  port_f_out,
  output logic      [7:0]  port_f_oe_n,
  output logic      [7:0]  port_f_pullup,
  // To peripherals
  output logic      [7:0]  pin_change_source_e,
  output logic             serial_port_external_clock,
  output logic             serial_receive_data,
  output logic             usi_data_input,
  output logic             usi_clock
);
  logic [7:0] port_e_value;
  logic [7:0] port_e_direction;
  logic [7:0] port_f_value;
  logic [7:0] port_f_direction;
  logic [7:0] pc_mask;
  logic [1:0] ctrl;
  logic [7:0] e_sync;
  logic [7:0] f_sync;
  logic [7:0] e_di_en;
  logic [7:0] f_di_en;
  logic [31:0] next_prdata;

  // Bus decode
  wire setup   = psel & ~penable;
  wire access  = psel & penable;
  wire wr_en   = access & pwrite & pready;
  wire hit_ev  = paddr == pm_pkg::OFF_E_VALUE;
  wire hit_ed  = paddr == pm_pkg::OFF_E_DIR;
  wire hit_ep  = paddr == pm_pkg::OFF_E_PIN;
  wire hit_fv  = paddr == pm_pkg::OFF_F_VALUE;
  wire hit_fd  = paddr == pm_pkg::OFF_F_DIR;
  wire hit_fp  = paddr == pm_pkg::OFF_F_PIN;
  wire hit_pm  = paddr == pm_pkg::OFF_PC_MASK;
  wire hit_ct  = paddr == pm_pkg::OFF_CTRL;
  wire mapped  = hit_ev | hit_ed | hit_ep | hit_fv | hit_fd | hit_fp | hit_pm | hit_ct;

  wire group_en = ctrl[pm_pkg::CTRL_GROUP_EN];
  wire global_pullup_disable      = ctrl[pm_pkg::CTRL_PUD];

  // Digital pin levels as software and peripherals see them
  wire [7:0] e_di = e_sync & e_di_en;
  wire [7:0] f_di = f_sync & f_di_en;

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hit_ev) next_prdata[7:0] = port_e_value;
    if (hit_ed) next_prdata[7:0] = port_e_direction;
    if (hit_ep) next_prdata[7:0] = e_di;
    if (hit_fv) next_prdata[7:0] = port_f_value;
    if (hit_fd) next_prdata[7:0] = port_f_direction;
    if (hit_fp) next_prdata[7:0] = f_di;
    if (hit_pm) next_prdata[7:0] = pc_mask;
    if (hit_ct) next_prdata[1:0] = ctrl;
  end

  // Answer one cycle after setup: every transfer takes exactly two cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= next_prdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_e_value     <= pm_pkg::RST_VALUE;
      port_e_direction <= pm_pkg::RST_DIR;
      port_f_value     <= pm_pkg::RST_VALUE;
      port_f_direction <= pm_pkg::RST_DIR;
      pc_mask          <= pm_pkg::RST_MASK;
      ctrl             <= pm_pkg::RST_CTRL;
    end else if (wr_en) begin
      if (hit_ev) port_e_value     <= pwdata[7:0];
      if (hit_ed) port_e_direction <= pwdata[7:0];
      if (hit_fv) port_f_value     <= pwdata[7:0];
      if (hit_fd) port_f_direction <= pwdata[7:0];
      if (hit_pm) pc_mask          <= pwdata[7:0];
      if (hit_ct) ctrl             <= pwdata[1:0];
    end
  end

  // Port E overrides
  wire       tw      = two_wire_mode_active;
  wire       xck_drv = serial_sync_mode & port_e_direction[2];
  wire [7:0] pc_on   = pc_mask & {8{group_en}};
  wire       sda_low = port_e_direction[5] & ~usi_data_bit;
  wire       scl_low = port_e_direction[4] & ~two_wire_clock_hold;

  wire [7:0] e_puoe = {2'b00, tw, tw, 1'b0, xck_drv, transmitter_enable,
                       receiver_enable};
  wire [7:0] e_puov = {7'h00, port_e_value[0] & ~global_pullup_disable};
  wire [7:0] e_ddoe = {clock_output_fuse, 1'b0, tw, tw, 2'b00,
                       transmitter_enable, receiver_enable};
  wire [7:0] e_ddov = {1'b1, 1'b0, sda_low, scl_low, 2'b00,
                       1'b1, 1'b0};
  wire [7:0] e_pvoe = {clock_output_fuse, three_wire_mode_active,
                       tw & port_e_direction[5], tw & port_e_direction[4],
                       1'b0, xck_drv, transmitter_enable, 1'b0};
  wire [7:0] e_pvov = {divided_clock_output, usi_data_out, 3'b000,
                       serial_clock_out, serial_transmit_data_pin,
                       1'b0};
  wire [7:0] e_dieoe = pc_on | {2'b00, usi_start_irq_enable,
                       usi_start_irq_enable, comp_neg_input_disable,
                       comp_pos_input_disable, 2'b00};
  wire [7:0] e_dieov = {4'hf, pc_on[3:2], 2'b11};

  // Port F overrides: the test port takes the upper nibble
  wire [7:0] f_take = pm_pkg::F_TEST_PINS & {8{test_port_enable}};
  wire [7:0] f_ddov = {1'b0, tap_shift_state, 6'h00};
  wire [7:0] f_pvoe = {1'b0, test_port_enable, 6'h00};
  wire [7:0] f_pvov = {1'b0, test_data_out, 6'h00};

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pins
      pm_pin_cell u_e (
        .pclk       (pclk),
        .port_value (port_e_value[i]),
        .direction  (port_e_direction[i]),
        .global_pullup_disable        (global_pullup_disable),
        .puoe       (e_puoe[i]),
        .puov       (e_puov[i]),
        .ddoe       (e_ddoe[i]),
        .ddov       (e_ddov[i]),
        .pvoe       (e_pvoe[i]),
        .pvov       (e_pvov[i]),
        .dieoe      (e_dieoe[i]),
        .dieov      (e_dieov[i]),
        .pin_out    (port_e_out[i]),
        .pin_oe_n   (port_e_oe_n[i]),
        .pin_pullup (port_e_pullup[i]),
        .di_en      (e_di_en[i])
      );
      // Pull-ups on test pins ride the enable, not the reset
      pm_pin_cell u_f (
        .pclk       (pclk),
        .port_value (port_f_value[i]),
        .direction  (port_f_direction[i]),
        .global_pullup_disable        (global_pullup_disable),
        .puoe       (f_take[i]),
        .puov       (pm_pkg::F_TEST_PULL[i]),
        .ddoe       (f_take[i]),
        .ddov       (f_ddov[i]),
        .pvoe       (f_pvoe[i]),
        .pvov       (f_pvov[i]),
        .dieoe      (f_take[i]),
        .dieov      (pm_pkg::F_TCK_DI[i]),
        .pin_out    (port_f_out[i]),
        .pin_oe_n   (port_f_oe_n[i]),
        .pin_pullup (port_f_pullup[i]),
        .di_en      (f_di_en[i])
      );
    end
  endgenerate

  pm_sync3 u_sync_e (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_async (port_e_in),
    .pin_sync  (e_sync)
  );

  pm_sync3 u_sync_f (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_async (port_f_in),
    .pin_sync  (f_sync)
  );

  // Peripheral inputs; the clock only counts when it is taken in
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_change_source_e        <= 8'h00;
      serial_port_external_clock <= 1'b0;
      serial_receive_data        <= 1'b0;
      usi_data_input             <= 1'b0;
      usi_clock                  <= 1'b0;
    end else begin
      pin_change_source_e        <= e_di;
      serial_port_external_clock <= serial_sync_mode & ~port_e_direction[2]
                                    & e_di[2];
      serial_receive_data        <= e_di[0];
      usi_data_input             <= e_di[5];
      usi_clock                  <= e_di[4];
    end
  end

  // Checks
  sequence seq_setup;
    psel && !penable;
  endsequence

  sequence seq_tdo_shift;
    test_port_enable && tap_shift_state;
  endsequence

  chk_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    seq_setup |=> pready ##1 !pready)
    else $error("APB answer not one cycle after setup");

  chk_clk_out_pin: assert property (@(posedge pclk) disable iff (!presetn)
    clock_output_fuse |=> !port_e_oe_n[7] && port_e_out[7] == $past(divided_clock_output))
    else $error("Divided clock missing on port E bit 7");

  chk_clk_in_reset: assert property (@(posedge pclk)
    (!presetn && clock_output_fuse) |=> port_e_out[7] == $past(divided_clock_output))
    else $error("Divided clock lost during reset");

  chk_pc_input_on: assert property (@(posedge pclk) disable iff (!presetn)
    (pc_on != 8'h00) |=> (($past(pc_on) & ~e_di_en) == 8'h00))
    else $error("Pin change input path disabled");

  chk_xck_master: assert property (@(posedge pclk) disable iff (!presetn)
    (serial_sync_mode && port_e_direction[2])
      |=> !port_e_oe_n[2] && port_e_out[2] == $past(serial_clock_out))
    else $error("External clock not driven as master");

  chk_xck_async_io: assert property (@(posedge pclk) disable iff (!presetn)
    !serial_sync_mode |=> port_e_out[2] == $past(port_e_value[2]))
    else $error("External clock active outside synchronous mode");

  chk_rx_input: assert property (@(posedge pclk) disable iff (!presetn)
    receiver_enable |=> port_e_oe_n[0])
    else $error("Receive pin not forced to input");

  chk_rx_pullup: assert property (@(posedge pclk) disable iff (!presetn)
    (receiver_enable && port_e_value[0] && !global_pullup_disable) |=> port_e_pullup[0])
    else $error("Receive pin pull-up missing");

  chk_test_pullups: assert property (@(posedge pclk)
    test_port_enable |=> port_f_pullup[7] && port_f_pullup[5] && port_f_pullup[4])
    else $error("Test port pull-ups off");

  chk_test_pins_owned: assert property (@(posedge pclk) disable iff (!presetn)
    test_port_enable |=> port_f_oe_n[7] && port_f_oe_n[5] && port_f_oe_n[4])
    else $error("Test port pins driven by port settings");

  chk_tdo_shift: assert property (@(posedge pclk) disable iff (!presetn)
    seq_tdo_shift |=> !port_f_oe_n[pm_pkg::F_TDO]
      && port_f_out[pm_pkg::F_TDO] == $past(test_data_out))
    else $error("Test data out not driven while shifting");

  chk_tdo_release: assert property (@(posedge pclk) disable iff (!presetn)
    (test_port_enable && !tap_shift_state)
      |=> port_f_oe_n[pm_pkg::F_TDO] && port_f_pullup[pm_pkg::F_TDO])
    else $error("Test data out not released");

  chk_tx_drive: assert property (@(posedge pclk) disable iff (!presetn)
    transmitter_enable |=> !port_e_oe_n[1] && !port_e_pullup[1]
      && port_e_out[1] == $past(serial_transmit_data_pin))
    else $error("Transmit pin not driven");

  chk_sda_low: assert property (@(posedge pclk) disable iff (!presetn)
    (tw && port_e_direction[5]) |=> port_e_oe_n[5] == $past(usi_data_bit)
      && !port_e_out[5] && !port_e_pullup[5])
    else $error("Two-wire data line drive wrong");

  sequence seq_scl_owned;
    two_wire_mode_active && port_e_direction[4];
  endsequence

  chk_scl_low: assert property (@(posedge pclk) disable iff (!presetn)
    seq_scl_owned |=> port_e_oe_n[4] == $past(two_wire_clock_hold)
      && !port_e_out[4] && !port_e_pullup[4])
    else $error("Two-wire clock line drive wrong");

  chk_xck_slave: assert property (@(posedge pclk) disable iff (!presetn)
    (serial_sync_mode && !port_e_direction[2])
      |=> port_e_oe_n[2] && serial_port_external_clock == $past(e_di[2]))
    else $error("External clock not taken in as slave");

  chk_xck_gated: assert property (@(posedge pclk) disable iff (!presetn)
    !serial_sync_mode |=> !serial_port_external_clock)
    else $error("External clock passed outside synchronous mode");

  chk_apb_refused: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_setup ##0 !mapped) |=> pready && pslverr)
    else $error("Unmapped access not refused");
endmodule : pm_port_ef

//--- verilog/pm_pkg.sv
package pm_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_E_VALUE  = 8'h00;
  localparam logic [7:0] OFF_E_DIR    = 8'h04;
  localparam logic [7:0] OFF_E_PIN    = 8'h08;
  localparam logic [7:0] OFF_F_VALUE  = 8'h0c;
  localparam logic [7:0] OFF_F_DIR    = 8'h10;
  localparam logic [7:0] OFF_F_PIN    = 8'h14;
  localparam logic [7:0] OFF_PC_MASK  = 8'h18;
  localparam logic [7:0] OFF_CTRL     = 8'h1c;
  // Control register fields
  localparam int unsigned CTRL_GROUP_EN = 0;
  localparam int unsigned CTRL_PUD      = 1;
  // Reset values
  localparam logic [7:0] RST_VALUE = 8'h00;
  localparam logic [7:0] RST_DIR   = 8'h00;
  localparam logic [7:0] RST_MASK  = 8'h00;
  localparam logic [1:0] RST_CTRL  = 2'h0;
  // Port F pins taken by the test port
  localparam logic [7:0] F_TEST_PINS  = 8'hf0;
  localparam logic [7:0] F_TEST_PULL  = 8'hf0;
  localparam logic [7:0] F_TCK_DI     = 8'h10;
  localparam int unsigned F_TDO       = 6;
endpackage : pm_pkg

//--- verilog/pm_sync3.sv
`timescale 1ns/1ns
module pm_sync3 (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Asynchronous pins and settled value
  input  wire logic [7:0] pin_async,
  output logic      [7:0] pin_sync
);
  logic [7:0] stage1;
  logic [7:0] stage2;
  logic [7:0] stage3;
  wire  [7:0] agree = ~(stage2 ^ stage3);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1   <= 8'h00;
      stage2   <= 8'h00;
      stage3   <= 8'h00;
      pin_sync <= 8'h00;
    end else begin
      stage1   <= pin_async;
      stage2   <= stage1;
      stage3   <= stage2;
      // A change counts only once two later stages agree
      pin_sync <= (agree & stage3) | (~agree & pin_sync);
    end
  end
endmodule : pm_sync3

//--- verilog/pm_pin_cell.sv
`timescale 1ns/1ns
module pm_pin_cell (
  // Clock
  input  wire logic pclk,
  // Port register bits
  input  wire logic port_value,
  input  wire logic direction,
  input  wire logic global_pullup_disable,
  // Override controls
  input  wire logic puoe,
  input  wire logic puov,
  input  wire logic ddoe,
  input  wire logic ddov,
  input  wire logic pvoe,
  input  wire logic pvov,
  input  wire logic dieoe,
  input  wire logic dieov,
  // Pad side
  output logic      pin_out,
  output logic      pin_oe_n,
  output logic      pin_pullup,
  output logic      di_en
);
  wire dir_eff = ddoe ? ddov : direction;
  wire val_eff = pvoe ? pvov : port_value;
  wire pu_eff  = puoe ? puov : (port_value & ~direction & ~global_pullup_disable);
  wire di_eff  = dieoe ? dieov : 1'b1;

  // No reset: clock output and test pull-ups must hold through reset
  always_ff @(posedge pclk) begin
    pin_out    <= val_eff;
    pin_oe_n   <= ~dir_eff;
    pin_pullup <= pu_eff & ~dir_eff;
    di_en      <= di_eff;
  end
endmodule : pm_pin_cell

//--- testbench/pm_pad_model.sv
`timescale 1ns/1ns
module pm_pad_model (
  // Clock
  input  wire logic       pclk,
  // Design pad side
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe_n,
  input  wire logic [7:0] pad_pullup,
  // Board drivers
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  // Resolved pin levels
  output logic      [7:0] pin
);
  // Floating pins wander so no stale level is held
  logic [7:0] wander = 8'h55;

  always @(posedge pclk) begin
    wander <= ~wander;
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin[i] = !pad_oe_n[i] ? pad_out[i] : ext_en[i] ? ext_val[i] :
               pad_pullup[i] ? 1'b1 : wander[i];
    end
  end
endmodule : pm_pad_model

//--- testbench/test_port_e_f_alternate_pin_override.sv
`timescale 1ns/1ns
module test_port_e_f_alternate_pin_override;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        clock_output_fuse, test_port_enable, tap_shift_state, test_data_out;
  logic        divided_clock_output, serial_sync_mode, serial_clock_out;
  logic        receiver_enable, transmitter_enable, serial_transmit_data_pin;
  logic        two_wire_mode_active, three_wire_mode_active, usi_data_out;
  logic        usi_data_bit, two_wire_clock_hold, usi_start_irq_enable;
  logic        comp_pos_input_disable, comp_neg_input_disable;
  logic [7:0]  port_e_in, port_e_out, port_e_oe_n, port_e_pullup;
  logic [7:0]  port_f_in, port_f_out, port_f_oe_n, port_f_pullup;
  logic [7:0]  pin_change_source_e, e_ext_val, e_ext_en, f_ext_val, f_ext_en;
  logic        serial_port_external_clock, serial_receive_data, usi_data_input, usi_clock;
  int          fails, n_compared;

  pm_port_ef DUT (.*);
  pm_pad_model u_pad_e (.pclk(pclk), .pad_out(port_e_out), .pad_oe_n(port_e_oe_n),
    .pad_pullup(port_e_pullup), .ext_val(e_ext_val), .ext_en(e_ext_en), .pin(port_e_in));
  pm_pad_model u_pad_f (.pclk(pclk), .pad_out(port_f_out), .pad_oe_n(port_f_oe_n),
    .pad_pullup(port_f_pullup), .ext_val(f_ext_val), .ext_en(f_ext_en), .pin(port_f_in));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task check(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task apb(input logic w, input logic [7:0] a, input logic [7:0] d,
           output logic [7:0] rd, output logic err);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, 24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    check("prdata_upper", 8'h00, {7'h0, |prdata[31:8]});
    check("pready_wait", 8'h01, 8'(n));
    {psel, penable} <= 2'b00;
  endtask : apb

  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] rd;
    logic       err;
    apb(1'b1, a, d, rd, err);
  endtask : wr

  task rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp, input logic e);
    logic [7:0] rd;
    logic       err;
    apb(1'b0, a, 8'h00, rd, err);
    check(name, exp, rd);
    check("pslverr", {7'h0, e}, {7'h0, err});
  endtask : rd_chk

  // Pad outputs lag by one edge, pad inputs by up to five; read at a rising edge
  task settle;
    repeat (8) @(posedge pclk);
  endtask : settle

  task t_regs;
    logic [7:0] rw [6];
    rw = '{pm_pkg::OFF_E_VALUE, pm_pkg::OFF_E_DIR, pm_pkg::OFF_F_VALUE,
           pm_pkg::OFF_F_DIR, pm_pkg::OFF_PC_MASK, pm_pkg::OFF_CTRL};
    for (int i = 0; i < 8; i++) rd_chk("reset_value", 8'(i * 4), 8'h00, 1'b0);
    rd_chk("unmapped", 8'h20, 8'h00, 1'b1);
    wr(8'h20, 8'hff);
    for (int i = 0; i < 6; i++) begin
      wr(rw[i], 8'h5a);
      rd_chk("readback", rw[i], (rw[i] == pm_pkg::OFF_CTRL) ? 8'h02 : 8'h5a, 1'b0);
      wr(rw[i], 8'h00);
    end
  endtask : t_regs

  task t_clock_out;
    @(posedge pclk);
    {clock_output_fuse, divided_clock_output} <= 2'b11;
    settle;
    check("e_out", 8'h80, port_e_out);
    check("e_oe_n", 8'h7f, port_e_oe_n);
    divided_clock_output <= 1'b0;
    settle;
    check("e_out", 8'h00, port_e_out);
    {test_port_enable, divided_clock_output, presetn} <= 3'b110;
    settle;
    check("e_out_rst", 8'h80, port_e_out);
    check("f_pullup_rst", 8'hf0, port_f_pullup);
    {presetn, clock_output_fuse, test_port_enable} <= 3'b100;
    settle;
  endtask : t_clock_out

  task t_test_port;
    // No conversion runs here, so port F outputs may switch freely
    wr(pm_pkg::OFF_F_DIR, 8'hff);
    wr(pm_pkg::OFF_F_VALUE, 8'hff);
    @(posedge pclk);
    {test_port_enable, tap_shift_state, test_data_out} <= 3'b101;
    settle;
    check("f_oe_n", 8'hf0, port_f_oe_n);
    check("f_pullup", 8'hf0, port_f_pullup);
    check("f_out_low", 8'h0f, port_f_out & 8'h0f);
    tap_shift_state <= 1'b1;
    settle;
    check("f_oe_n", 8'hb0, port_f_oe_n);
    check("tdo", 8'h40, port_f_out & 8'h40);
    test_data_out <= 1'b0;
    settle;
    check("tdo", 8'h00, port_f_out & 8'h40);
    {test_port_enable, tap_shift_state} <= 2'b00;
    settle;
    check("f_oe_n", 8'h00, port_f_oe_n);
    wr(pm_pkg::OFF_F_DIR, 8'h00);
    wr(pm_pkg::OFF_F_VALUE, 8'h00);
  endtask : t_test_port

  task t_serial_clock;
    @(posedge pclk);
    {serial_sync_mode, serial_clock_out} <= 2'b11;
    wr(pm_pkg::OFF_E_DIR, 8'h04);
    settle;
    check("xck_out", 8'h04, port_e_out & 8'h04);
    check("xck_oe_n", 8'h00, port_e_oe_n & 8'h04);
    wr(pm_pkg::OFF_E_DIR, 8'h00);
    e_ext_val <= 8'h04;
    settle;
    check("xck_in", 8'h01, {7'h0, serial_port_external_clock});
    e_ext_val <= 8'h00;
    settle;
    check("xck_in", 8'h00, {7'h0, serial_port_external_clock});
    serial_sync_mode <= 1'b0;
    wr(pm_pkg::OFF_E_DIR, 8'h04);
    settle;
    check("e2_plain", 8'h00, port_e_out & 8'h04);
    wr(pm_pkg::OFF_E_DIR, 8'h00);
  endtask : t_serial_clock

  task t_receiver;
    wr(pm_pkg::OFF_E_DIR, 8'hff);
    wr(pm_pkg::OFF_E_VALUE, 8'h01);
    {receiver_enable, e_ext_en} <= {1'b1, 8'hfe};
    settle;
    check("rx_oe_n", 8'h01, port_e_oe_n & 8'h01);
    check("rx_pullup", 8'h01, port_e_pullup & 8'h01);
    check("rx_data", 8'h01, {7'h0, serial_receive_data});
    wr(pm_pkg::OFF_CTRL, 8'h02);
    settle;
    check("rx_pullup", 8'h00, port_e_pullup & 8'h01);
    wr(pm_pkg::OFF_CTRL, 8'h00);
    {receiver_enable, e_ext_en} <= {1'b0, 8'hff};
    wr(pm_pkg::OFF_E_VALUE, 8'h00);
    wr(pm_pkg::OFF_E_DIR, 8'h00);
  endtask : t_receiver

  task t_transmit;
    wr(pm_pkg::OFF_E_VALUE, 8'h02);
    {transmitter_enable, serial_transmit_data_pin} <= 2'b11;
    settle;
    check("tx_oe_n", 8'h00, port_e_oe_n & 8'h02);
    check("tx_pullup", 8'h00, port_e_pullup & 8'h02);
    check("tx_out", 8'h02, port_e_out & 8'h02);
    serial_transmit_data_pin <= 1'b0;
    settle;
    check("tx_out", 8'h00, port_e_out & 8'h02);
    {three_wire_mode_active, usi_data_out} <= 2'b11;
    wr(pm_pkg::OFF_E_DIR, 8'h40);
    settle;
    check("usi_do_out", 8'h40, port_e_out & 8'h40);
    check("usi_do_oe_n", 8'h00, port_e_oe_n & 8'h40);
    {three_wire_mode_active, usi_data_out} <= 2'b00;
    wr(pm_pkg::OFF_E_DIR, 8'h00);
    transmitter_enable <= 1'b0;
    wr(pm_pkg::OFF_E_VALUE, 8'h00);
  endtask : t_transmit

  task t_two_wire;
    wr(pm_pkg::OFF_E_DIR, 8'h30);
    wr(pm_pkg::OFF_E_VALUE, 8'h30);
    {two_wire_mode_active, usi_data_bit, two_wire_clock_hold} <= 3'b100;
    settle;
    check("tw_oe_n", 8'h00, port_e_oe_n & 8'h30);
    check("tw_out", 8'h00, port_e_out & 8'h30);
    check("tw_pullup", 8'h00, port_e_pullup & 8'h30);
    usi_data_bit <= 1'b1;
    settle;
    check("tw_oe_n", 8'h20, port_e_oe_n & 8'h30);
    {two_wire_clock_hold, e_ext_val} <= {1'b1, 8'h20};
    settle;
    check("tw_oe_n", 8'h30, port_e_oe_n & 8'h30);
    check("usi_in", 8'h02, {6'h0, usi_data_input, usi_clock});
    {two_wire_mode_active, e_ext_val} <= {1'b0, 8'h00};
    wr(pm_pkg::OFF_E_DIR, 8'h00);
    wr(pm_pkg::OFF_E_VALUE, 8'h00);
  endtask : t_two_wire

  task t_pin_change;
    wr(pm_pkg::OFF_PC_MASK, 8'hff);
    {comp_pos_input_disable, comp_neg_input_disable, usi_start_irq_enable} <= 3'b111;
    e_ext_val <= 8'ha5;
    settle;
    check("pc_src_off", 8'ha1, pin_change_source_e);
    wr(pm_pkg::OFF_CTRL, 8'h01);
    settle;
    check("pc_src", 8'ha5, pin_change_source_e);
    rd_chk("e_pin", pm_pkg::OFF_E_PIN, 8'ha5, 1'b0);
    e_ext_val <= 8'h5a;
    settle;
    check("pc_src", 8'h5a, pin_change_source_e);
  endtask : t_pin_change

  task finish_test;
    if (fails == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    finish_test();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {clock_output_fuse, test_port_enable, tap_shift_state, test_data_out} = '0;
    {divided_clock_output, serial_sync_mode, serial_clock_out, receiver_enable} = '0;
    {transmitter_enable, serial_transmit_data_pin, two_wire_mode_active} = '0;
    {three_wire_mode_active, usi_data_out, usi_data_bit, two_wire_clock_hold} = '0;
    {usi_start_irq_enable, comp_pos_input_disable, comp_neg_input_disable} = '0;
    {e_ext_val, e_ext_en, f_ext_val, f_ext_en} = {8'h00, 8'hff, 8'h00, 8'hff};
    fails = 0;
    n_compared = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_clock_out();
    t_test_port();
    t_serial_clock();
    t_receiver();
    t_transmit();
    t_two_wire();
    t_pin_change();
    finish_test();
  end
endmodule : test_port_e_f_alternate_pin_override
